// ===== rtl/spsp_pkg.sv
/*
 * Constants for the standalone port status pin block: APB register map,
 * field positions, reset values, mode and charge level encodings.
 * Assumes a 32-bit APB master on the same 50 MHz clock as the block.
 */
`default_nettype none

package spsp_pkg;

    localparam int unsigned SPSP_ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] SPSP_CTRL_OFS = 8'h00;
    localparam logic [7:0] SPSP_STATUS_OFS = 8'h04;
    localparam logic [7:0] SPSP_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] SPSP_IRQ_CLR_OFS = 8'h0C;
    localparam logic [7:0] SPSP_IRQ_EN_OFS = 8'h10;

    // Standalone operating mode, held in CTRL[1:0]
    typedef enum logic [1:0] {
        SPSP_MODE_OFF = 2'b00,
        SPSP_MODE_DFP = 2'b01,
        SPSP_MODE_UFP = 2'b10,
        SPSP_MODE_BAD = 2'b11
    } spsp_mode_t;

    // Charge level codes
    localparam logic [1:0] SPSP_LVL_USB2 = 2'h0;
    localparam logic [1:0] SPSP_LVL_USB3 = 2'h1;
    localparam logic [1:0] SPSP_LVL_1A5 = 2'h2;
    localparam logic [1:0] SPSP_LVL_3A0 = 2'h3;

    // Interrupt bit positions (status, clear and enable share them)
    localparam int unsigned SPSP_IRQ_W = 3;
    localparam int unsigned SPSP_IRQ_NOTICE = 0;
    localparam int unsigned SPSP_IRQ_LOCAL = 1;
    localparam int unsigned SPSP_IRQ_ORIENT = 2;

    // STATUS field positions
    localparam int unsigned SPSP_ST_ORIENT = 0;
    localparam int unsigned SPSP_ST_ORIENT_VLD = 1;
    localparam int unsigned SPSP_ST_LVL_LSB = 2;
    localparam int unsigned SPSP_ST_PWR_REQ = 4;
    localparam int unsigned SPSP_ST_SW_EN = 5;
    localparam int unsigned SPSP_ST_NOTICE = 6;
    localparam int unsigned SPSP_ST_LOCAL = 7;
    localparam int unsigned SPSP_ST_MODE_LSB = 8;

    // Reset values
    localparam logic [1:0] SPSP_CTRL_RST = 2'h0;
    localparam logic [2:0] SPSP_IRQ_EN_RST = 3'h0;

endpackage : spsp_pkg

`default_nettype wire

// ===== rtl/spsp_port_pins.sv
/*
 * Standalone port status pin logic: plug orientation, port power switch
 * drive, charge level capture, overcurrent report and notice, and the
 * alert interrupt, with an APB register slave.
 * Assumes all pin inputs are synchronous to clk_i and that the CC
 * comparator results arrive as ready-made levels.
 */
`default_nettype none

module spsp_port_pins
    import spsp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [SPSP_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // CC comparator results
    input wire logic cc1_sink_term_i,
    input wire logic cc2_sink_term_i,
    input wire logic cc1_above_cc2_i,
    input wire logic cc2_above_cc1_i,
    // Hub side pins
    input wire logic port_power_switch_request_i,
    input wire logic charge_level_sel_lo_i,
    input wire logic charge_level_sel_hi_i,
    input wire logic overcurrent_notice_n_i,
    output logic overcurrent_report_n_o,
    output logic overcurrent_report_oe_o,
    // External power switch
    input wire logic external_power_switch_fault_n_i,
    output logic external_power_switch_en_o,
    // Orientation and charge level
    output logic orientation_o,
    output logic orientation_oe_o,
    output logic [1:0] charge_level_o,
    // Interrupt
    output logic irq_o,
    output logic alert_n_o,
    output logic alert_oe_o
);

    typedef struct packed {
        spsp_mode_t mode;
        logic [SPSP_IRQ_W-1:0] irq_en;
        logic [SPSP_IRQ_W-1:0] irq_stat;
        logic orient;
        logic orient_oe;
        logic cap_done;
        logic [1:0] cap_lvl;
        logic [1:0] lvl_out;
        logic sw_en;
        logic report_oe;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } spsp_state_t;

    spsp_state_t s_r;
    spsp_state_t s_nxt;

    logic is_dfp;
    logic is_ufp;
    logic notice_act;
    logic local_fault;
    logic acc;
    logic wr_done;
    logic mapped;
    logic [31:0] rd_val;
    logic [SPSP_IRQ_W-1:0] ev;
    logic [SPSP_IRQ_W-1:0] clr;

    assign is_dfp = (s_r.mode == SPSP_MODE_DFP);
    assign is_ufp = (s_r.mode == SPSP_MODE_UFP);
    // Hub-side and switch-side faults only count in DFP mode
    assign notice_act = is_dfp && !overcurrent_notice_n_i;
    assign local_fault = is_dfp && !external_power_switch_fault_n_i;
    assign acc = psel_i && penable_i;
    assign wr_done = acc && s_r.pready && pwrite_i;

    always_comb begin
        unique case (paddr_i)
            SPSP_CTRL_OFS,
            SPSP_STATUS_OFS,
            SPSP_IRQ_STAT_OFS,
            SPSP_IRQ_CLR_OFS,
            SPSP_IRQ_EN_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (paddr_i)
            SPSP_CTRL_OFS: rd_val[1:0] = s_r.mode;
            SPSP_STATUS_OFS: begin
                rd_val[SPSP_ST_ORIENT] = s_r.orient;
                rd_val[SPSP_ST_ORIENT_VLD] = s_r.orient_oe;
                rd_val[SPSP_ST_LVL_LSB +: 2] = s_r.cap_lvl;
                rd_val[SPSP_ST_PWR_REQ] = port_power_switch_request_i;
                rd_val[SPSP_ST_SW_EN] = s_r.sw_en;
                rd_val[SPSP_ST_NOTICE] = notice_act;
                rd_val[SPSP_ST_LOCAL] = local_fault;
                rd_val[SPSP_ST_MODE_LSB +: 2] = s_r.mode;
            end
            SPSP_IRQ_STAT_OFS: rd_val[SPSP_IRQ_W-1:0] = s_r.irq_stat;
            SPSP_IRQ_EN_OFS: rd_val[SPSP_IRQ_W-1:0] = s_r.irq_en;
            // Clear register is write-only and reads as zero
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        s_nxt = s_r;

        // APB: one wait state, then the write lands at the pready edge
        if (acc && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = !mapped;
            s_nxt.prdata = (pwrite_i || !mapped) ? 32'h0000_0000 : rd_val;
        end else begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
        end

        clr = '0;
        if (wr_done && mapped) begin
            unique case (paddr_i)
                SPSP_CTRL_OFS: begin
                    s_nxt.mode = spsp_mode_t'(pwdata_i[1:0]);
                end
                SPSP_IRQ_CLR_OFS: clr = pwdata_i[SPSP_IRQ_W-1:0];
                SPSP_IRQ_EN_OFS: s_nxt.irq_en = pwdata_i[SPSP_IRQ_W-1:0];
                default: s_nxt.irq_en = s_r.irq_en;
            endcase
        end

        // Orientation: hold the last answer while nothing decisive is seen
        if (is_dfp) begin
            if (cc1_sink_term_i && !cc2_sink_term_i) begin
                s_nxt.orient = 1'b0;
            end else if (cc2_sink_term_i && !cc1_sink_term_i) begin
                s_nxt.orient = 1'b1;
            end
        end else if (is_ufp) begin
            if (cc1_above_cc2_i && !cc2_above_cc1_i) begin
                s_nxt.orient = 1'b0;
            end else if (cc2_above_cc1_i && !cc1_above_cc2_i) begin
                s_nxt.orient = 1'b1;
            end
        end
        s_nxt.orient_oe = is_dfp || is_ufp;

        // Charge level is caught on the first edge after reset release only
        if (!s_r.cap_done) begin
            s_nxt.cap_done = 1'b1;
            s_nxt.cap_lvl = {charge_level_sel_hi_i, charge_level_sel_lo_i};
        end
        // Codes map one to one onto SPSP_LVL_USB2 .. SPSP_LVL_3A0
        s_nxt.lvl_out = is_dfp ? s_r.cap_lvl : SPSP_LVL_USB2;

        // A local switch fault drops port power until the fault clears
        s_nxt.sw_en = is_dfp && port_power_switch_request_i
            && !local_fault;
        s_nxt.report_oe = local_fault;

        ev = '0;
        ev[SPSP_IRQ_NOTICE] = notice_act;
        ev[SPSP_IRQ_LOCAL] = local_fault;
        ev[SPSP_IRQ_ORIENT] = s_r.orient_oe && (s_nxt.orient != s_r.orient);
        // A new event wins over a clear in the same cycle
        s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.mode <= spsp_mode_t'(SPSP_CTRL_RST);
            s_r.irq_en <= SPSP_IRQ_EN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o = s_r.prdata;
    assign pready_o = s_r.pready;
    assign pslverr_o = s_r.pslverr;
    assign orientation_o = s_r.orient;
    assign orientation_oe_o = s_r.orient_oe;
    assign charge_level_o = s_r.lvl_out;
    assign external_power_switch_en_o = s_r.sw_en;
    // Open-drain pins: value is always low, the enable does the work
    assign overcurrent_report_n_o = 1'b0;
    assign overcurrent_report_oe_o = s_r.report_oe;
    assign irq_o = s_r.irq;
    assign alert_n_o = 1'b0;
    assign alert_oe_o = s_r.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_dfp_orient_cc1;
        is_dfp && cc1_sink_term_i && !cc2_sink_term_i |=> !orientation_o;
    endproperty
    a_dfp_orient_cc1: assert property (p_dfp_orient_cc1)
        else $error("DFP orientation not low with sink on CC1");

    property p_dfp_orient_cc2;
        is_dfp && !cc1_sink_term_i && cc2_sink_term_i ##1 is_dfp
            |-> orientation_o && orientation_oe_o;
    endproperty
    a_dfp_orient_cc2: assert property (p_dfp_orient_cc2)
        else $error("DFP orientation not driven high with sink on CC2");

    property p_ufp_orient;
        is_ufp && (cc1_above_cc2_i != cc2_above_cc1_i)
            |=> orientation_o == $past(cc2_above_cc1_i);
    endproperty
    a_ufp_orient: assert property (p_ufp_orient)
        else $error("UFP orientation does not follow the higher CC pin");

    property p_power_on;
        is_dfp && port_power_switch_request_i && external_power_switch_fault_n_i
            |=> external_power_switch_en_o;
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("Power request did not enable the switch");

    property p_power_off;
        !port_power_switch_request_i || !is_dfp |=> !external_power_switch_en_o;
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("Switch enabled without request in DFP mode");

    property p_charge_level;
        s_r.cap_done && is_dfp |=> charge_level_o == $past(s_r.cap_lvl);
    endproperty
    a_charge_level: assert property (p_charge_level)
        else $error("Charge level output differs from captured code");

    property p_capture_once;
        s_r.cap_done |=> $stable(s_r.cap_lvl) && s_r.cap_done;
    endproperty
    a_capture_once: assert property (p_capture_once)
        else $error("Captured charge level changed after reset release");

    property p_report;
        is_dfp && !external_power_switch_fault_n_i |=> overcurrent_report_oe_o
            && !overcurrent_report_n_o;
    endproperty
    a_report: assert property (p_report)
        else $error("Local fault not reported to the hub");

    property p_notice_irq;
        is_dfp && !overcurrent_notice_n_i |=> s_r.irq_stat[SPSP_IRQ_NOTICE];
    endproperty
    a_notice_irq: assert property (p_notice_irq)
        else $error("Overcurrent notice did not set its interrupt bit");

    property p_alert;
        |(s_r.irq_stat & s_r.irq_en) |-> alert_oe_o && irq_o;
    endproperty
    a_alert: assert property (p_alert)
        else $error("Alert not asserted with an enabled pending bit");

    property p_unused;
        s_r.mode == SPSP_MODE_OFF ##1 s_r.mode == SPSP_MODE_OFF
            |-> !orientation_oe_o && !external_power_switch_en_o
            && !overcurrent_report_oe_o && charge_level_o == SPSP_LVL_USB2;
    endproperty
    a_unused: assert property (p_unused)
        else $error("Standalone pins active while no mode selected");

    property p_dfp_hold;
        is_dfp && (cc1_sink_term_i == cc2_sink_term_i) |=> $stable(orientation_o);
    endproperty
    a_dfp_hold: assert property (p_dfp_hold)
        else $error("DFP orientation moved with no decisive termination");

    property p_ufp_hold;
        is_ufp && (cc1_above_cc2_i == cc2_above_cc1_i) |=> $stable(orientation_o);
    endproperty
    a_ufp_hold: assert property (p_ufp_hold)
        else $error("UFP orientation moved with no higher CC pin");

    property p_ufp_quiet;
        is_ufp |=> !external_power_switch_en_o && !overcurrent_report_oe_o
            && charge_level_o == SPSP_LVL_USB2;
    endproperty
    a_ufp_quiet: assert property (p_ufp_quiet)
        else $error("DFP-only pins active in UFP mode");

    property p_bad_mode_quiet;
        s_r.mode == SPSP_MODE_BAD |=> !orientation_oe_o && !external_power_switch_en_o
            && !overcurrent_report_oe_o && charge_level_o == SPSP_LVL_USB2;
    endproperty
    a_bad_mode_quiet: assert property (p_bad_mode_quiet)
        else $error("Standalone pins active with the reserved mode code");

    property p_fault_drops_power;
        local_fault |=> !external_power_switch_en_o;
    endproperty
    a_fault_drops_power: assert property (p_fault_drops_power)
        else $error("Switch left enabled during a local fault");

    property p_report_release;
        !local_fault |=> !overcurrent_report_oe_o;
    endproperty
    a_report_release: assert property (p_report_release)
        else $error("Overcurrent report pulled low with no local fault");

    property p_notice_sticky;
        s_r.irq_stat[SPSP_IRQ_NOTICE]
            && !(wr_done && paddr_i == SPSP_IRQ_CLR_OFS && pwdata_i[SPSP_IRQ_NOTICE])
            |=> s_r.irq_stat[SPSP_IRQ_NOTICE];
    endproperty
    a_notice_sticky: assert property (p_notice_sticky)
        else $error("Notice interrupt bit dropped without a clear");

    property p_capture_first;
        !s_r.cap_done |=> s_r.cap_lvl
            == {$past(charge_level_sel_hi_i), $past(charge_level_sel_lo_i)};
    endproperty
    a_capture_first: assert property (p_capture_first)
        else $error("Charge level not captured on the first edge after reset");

    c_dfp_cc2: cover property (is_dfp && cc2_sink_term_i ##1 orientation_o);
    c_notice_alert: cover property (notice_act ##[1:3] alert_oe_o);
    c_ufp_flip: cover property (is_ufp ##1 $rose(orientation_o));
    c_apb_read: cover property (acc && pready_o && !pwrite_i && !pslverr_o);
    c_fault_report: cover property (local_fault ##1 overcurrent_report_oe_o);

endmodule : spsp_port_pins

`default_nettype wire

// ===== dv/spsp_hub_model.sv
/*
 * Partner hub model: drives the port power request, the charge level
 * select pins and the overcurrent notice, and sees the report line.
 * Assumes bench commands change on rising edges of clk_i.
 */
`default_nettype none

module spsp_hub_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench commands
    input wire logic want_power_i,
    input wire logic hub_fault_i,
    input wire logic [1:0] cap_i,
    input wire logic report_oe_i,
    input wire logic report_n_i,
    // Device side pins
    output logic port_power_switch_request_o,
    output logic charge_level_sel_lo_o,
    output logic charge_level_sel_hi_o,
    output logic overcurrent_notice_n_o,
    output logic report_level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cap_r;

    // Code only follows the bench during reset, so the pins stay still after it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_r <= cap_i;
        end
    end
    assign port_power_switch_request_o = want_power_i;
    assign {charge_level_sel_hi_o, charge_level_sel_lo_o} = cap_r;
    assign overcurrent_notice_n_o = ~hub_fault_i;
    // Open-drain report line with a pull-up
    assign report_level_o = report_oe_i ? report_n_i : 1'b1;
endmodule // spsp_hub_model

`default_nettype wire

// ===== dv/spsp_port_pins_tb_top.sv
/*
 * Self-checking bench for the standalone port status pins block.
 * Assumes pin outputs follow their causes one clock edge later.
 */
`default_nettype none

module spsp_port_pins_tb_top;
    import spsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, q;
    logic pready_o, pslverr_o, last_err;
    logic cc1s = 1'b0, cc2s = 1'b0, c1a = 1'b0, c2a = 1'b0, fault_n = 1'b1;
    logic want_pwr = 1'b0, hub_fault = 1'b0;
    logic [1:0] cap = 2'h3, lvl;
    logic req, sel_lo, sel_hi, notice_n, rep_oe, rep_lvl, sw_en, orient, orient_oe, irq, alert_oe;
    int n_fail = 0;
    int check_count = 0;
    logic rep_n, alert_n, alert_lvl;
    // Alert line as seen through its board pull-up
    assign alert_lvl = alert_oe ? alert_n : 1'b1;

    always #10 clk_i = ~clk_i;

    spsp_hub_model HUB (.clk_i(clk_i), .rst_i(rst_i), .want_power_i(want_pwr),
        .hub_fault_i(hub_fault), .cap_i(cap), .report_oe_i(rep_oe), .report_n_i(rep_n),
        .port_power_switch_request_o(req), .charge_level_sel_lo_o(sel_lo),
        .charge_level_sel_hi_o(sel_hi), .overcurrent_notice_n_o(notice_n),
        .report_level_o(rep_lvl));

    spsp_port_pins DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .cc1_sink_term_i(cc1s),
        .cc2_sink_term_i(cc2s), .cc1_above_cc2_i(c1a), .cc2_above_cc1_i(c2a),
        .port_power_switch_request_i(req), .charge_level_sel_lo_i(sel_lo),
        .charge_level_sel_hi_i(sel_hi), .overcurrent_notice_n_i(notice_n),
        .overcurrent_report_n_o(rep_n), .overcurrent_report_oe_o(rep_oe),
        .external_power_switch_fault_n_i(fault_n), .external_power_switch_en_o(sw_en),
        .orientation_o(orient), .orientation_oe_o(orient_oe), .charge_level_o(lvl),
        .irq_o(irq), .alert_n_o(alert_n), .alert_oe_o(alert_oe));

    task automatic wrap_up;
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Pready is taken at rising edges; only the watchdog ends a wait that never answers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = prdata_o;
        last_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic settle;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    initial begin
        repeat (6000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(1'b0, SPSP_CTRL_OFS, 32'h0000_0000);
        chk("ctrl_reset", 32'(SPSP_CTRL_RST), q);
        apb(1'b0, SPSP_IRQ_EN_OFS, 32'h0000_0000);
        chk("irq_en_reset", 32'(SPSP_IRQ_EN_RST), q);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk("unmapped_err", 32'h0000_0001, {31'h0, last_err});
        chk("off_level", 32'h0000_0000, {30'h0, lvl});
        for (int c = 0; c < 4; c++) begin
            cap <= c[1:0];
            do_reset();
            apb(1'b1, SPSP_CTRL_OFS, 32'(SPSP_MODE_DFP));
            settle();
            chk("charge_level", 32'(c), {30'h0, lvl});
            apb(1'b0, SPSP_STATUS_OFS, 32'h0000_0000);
            chk("status_level", 32'(c), {30'h0, q[3:2]});
        end
        @(posedge clk_i);
        cc2s <= 1'b1;
        settle();
        chk("dfp_cc2", 32'h0000_0003, {30'h0, orient_oe, orient});
        @(posedge clk_i);
        cc2s <= 1'b0;
        cc1s <= 1'b1;
        want_pwr <= 1'b1;
        settle();
        chk("dfp_cc1", 32'h0000_0002, {30'h0, orient_oe, orient});
        apb(1'b1, SPSP_CTRL_OFS, 32'(SPSP_MODE_UFP));
        c2a <= 1'b1;
        settle();
        chk("ufp_cc2_high", 32'h0000_0003, {30'h0, orient_oe, orient});
        chk("ufp_power", 32'h0000_0000, {31'h0, sw_en});
        @(posedge clk_i);
        c2a <= 1'b0;
        c1a <= 1'b1;
        settle();
        chk("ufp_cc1_high", 32'h0000_0002, {30'h0, orient_oe, orient});
        apb(1'b1, SPSP_CTRL_OFS, 32'(SPSP_MODE_DFP));
        settle();
        chk("dfp_power", 32'h0000_0001, {31'h0, sw_en});
        @(posedge clk_i);
        fault_n <= 1'b0;
        settle();
        chk("report_line", 32'h0000_0000, {31'h0, rep_lvl});
        chk("fault_power", 32'h0000_0000, {31'h0, sw_en});
        @(posedge clk_i);
        fault_n <= 1'b1;
        apb(1'b0, SPSP_IRQ_STAT_OFS, 32'h0000_0000);
        chk("stat_events", 32'h0000_0006, q);
        apb(1'b1, SPSP_IRQ_CLR_OFS, 32'h0000_0007);
        apb(1'b1, SPSP_IRQ_EN_OFS, 32'h0000_0001);
        settle();
        chk("irq_quiet", 32'h0000_0001, {30'h0, irq, alert_lvl});
        @(posedge clk_i);
        hub_fault <= 1'b1;
        settle();
        chk("irq_notice", 32'h0000_0002, {30'h0, irq, alert_lvl});
        @(posedge clk_i);
        hub_fault <= 1'b0;
        apb(1'b1, SPSP_IRQ_EN_OFS, 32'h0000_0000);
        settle();
        chk("irq_masked", 32'h0000_0001, {30'h0, irq, alert_lvl});
        apb(1'b0, SPSP_IRQ_STAT_OFS, 32'h0000_0000);
        chk("stat_sticky", 32'h0000_0001, q & 32'h0000_0001);
        apb(1'b1, SPSP_IRQ_CLR_OFS, 32'h0000_0007);
        apb(1'b0, SPSP_IRQ_STAT_OFS, 32'h0000_0000);
        chk("stat_cleared", 32'h0000_0000, q);
        apb(1'b1, SPSP_CTRL_OFS, 32'(SPSP_MODE_BAD));
        settle();
        chk("bad_mode_pins", 32'h0000_0000, {28'h0, orient_oe, sw_en, lvl});
        apb(1'b1, SPSP_CTRL_OFS, 32'(SPSP_MODE_DFP));
        settle();
        apb(1'b1, SPSP_CTRL_OFS, 32'(SPSP_MODE_OFF));
        settle();
        chk("off_pins", 32'h0000_0000, {30'h0, orient_oe, sw_en});
        wrap_up();
    end
endmodule // spsp_port_pins_tb_top

`default_nettype wire
